/* bench/rffe_master_model.sv */
// Bus master model: link clock, data wire and sequences.
// Assumes clk_sys paces it; the slave's data pins resolve here.
`timescale 1ns/1ps
`default_nettype none
module rffe_master_model (
	// Clock and slave side
	input wire logic clk_sys,
	input wire logic sdata_out,
	input wire logic sdata_oe,
	// Link
	output logic sclk,
	output wire logic sdata
);
	logic m_oe = 1'b1;
	logic m_d = 1'b0;
	// A released wire must not keep the last value
	assign sdata = sdata_oe ? sdata_out : (m_oe ? m_d : ~sdata_out);
	initial
		sclk = 1'b0;
	// Launch on the rise, sample on the fall
	task automatic bit_t(input logic b, input logic drv, output logic s);
		@(negedge clk_sys);
		sclk = 1'b1;
		m_oe = drv;
		m_d = b;
		repeat (4) @(negedge clk_sys);
		s = sdata;
		sclk = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic seq(input logic [3:0] id, input logic [7:0] cmd, input logic [7:0] dat, input logic bp,
		output logic [8:0] q);
		logic s;
		logic [11:0] f;
		f = {id, cmd};
		q = 9'h000;
		m_oe = 1'b1;
		m_d = 1'b1;
		repeat (4) @(negedge clk_sys);
		m_d = 1'b0;
		repeat (4) @(negedge clk_sys);
		for (int i = 11; i >= 0; i--)
			bit_t(f[i], 1'b1, s);
		bit_t(~^f ^ bp, 1'b1, s);
		if (cmd[7:5] == 3'h2)
			for (int i = 8; i >= 0; i--)
				bit_t(i ? dat[i-1] : ~^dat, 1'b1, s);
		bit_t(1'b0, 1'b1, s);
		if (cmd[7:5] == 3'h3)
		begin
			for (int i = 0; i < 10; i++)
			begin
				bit_t(1'b0, 1'b0, s);
				q = i < 9 ? {q[7:0], s} : q;
			end
			repeat (8) @(negedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

/* bench/rffe_switch_control_slave_bench.sv */
// Testbench for the RF switch control slave.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rffe_switch_control_slave_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic so, oe, sclk, sd, p1, p2, p3, p4, lp;
	int bad_count = 0;
	int checked = 0;
	wire logic [8:0] st = {1'b0, lp, 3'h0, p4, p3, p2, p1};
	rffe_switch_control_slave u_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .sdata_in(sd), .sdata_out(so),
		.sdata_oe(oe), .path_one_on(p1), .path_two_on(p2), .path_three_on(p3), .path_four_on(p4),
		.low_power_select(lp));
	rffe_master_model u_m (.clk_sys(clk_sys), .sdata_out(so), .sdata_oe(oe), .sclk(sclk), .sdata(sd));
	initial forever #25 clk_sys = ~clk_sys;
	task chk(input string n, input logic [8:0] e, input logic [8:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task send(input logic [3:0] id, input logic [7:0] cmd, input logic [7:0] d, input logic bp);
		logic [8:0] q;
		u_m.seq(id, cmd, d, bp, q);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		logic [8:0] q;
		u_m.seq(4'h8, {3'h3, a}, 8'h00, 1'b0, q);
		chk("read", {e, ~^e}, q);
	endtask
	task t_shadow;
		chk("reset", 9'h000, st);
		rd(5'h1C, 8'h00);
		send(4'h8, 8'h40, 8'h02, 1'b0);
		chk("shadow", 9'h000, st);
		send(4'h8, 8'h5C, 8'h06, 1'b0);
		chk("trig 2 1", 9'h000, st);
		send(4'h8, 8'h5C, 8'h01, 1'b0);
		chk("trig 0", 9'h002, st);
		$display("shadow test done");
	endtask
	task t_mask;
		send(4'h8, 8'h5C, 8'h08, 1'b0);
		rd(5'h1C, 8'h08);
		send(4'h8, 8'h40, 8'h08, 1'b0);
		chk("direct", 9'h008, st);
		send(4'h8, 8'hC4, 8'h00, 1'b0);
		chk("reg0", 9'h004, st);
		rd(5'h00, 8'h44);
		$display("mask test done");
	endtask
	task t_power;
		send(4'h8, 8'h5C, 8'h88, 1'b0);
		chk("low power", 9'h084, st);
		rd(5'h1C, 8'h88);
		send(4'h3, 8'h40, 8'h01, 1'b0);
		send(4'h8, 8'h40, 8'h01, 1'b1);
		send(4'h0, 8'h40, 8'h01, 1'b0);
		send(4'h0, 8'h5C, 8'h08, 1'b0);
		chk("refusals", 9'h004, st);
		$display("power test done");
	endtask
	task t_soft;
		send(4'h8, 8'h5C, 8'hC8, 1'b0);
		chk("soft reset", 9'h000, st);
		rd(5'h1C, 8'h00);
		send(4'h8, 8'h40, 8'h01, 1'b0);
		chk("mask default", 9'h000, st);
		$display("soft reset test done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// About 20 sequences of up to 26 bit times; ample margin
	initial
	begin
		#2000000;
		bad_count++;
		finish_test;
	end
	initial
	begin
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_shadow;
		t_mask;
		t_power;
		t_soft;
		finish_test;
	end
endmodule
`default_nettype wire

/* bench/rffe_switch_sva.sv */
// Checker for the RF switch control slave.
// Assumes it is bound to the slave's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module rffe_switch_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link and switch outputs
	input wire logic sclk,
	input wire logic sdata_out,
	input wire logic sdata_oe,
	input wire logic path_one_on,
	input wire logic path_two_on,
	input wire logic path_three_on,
	input wire logic path_four_on,
	input wire logic low_power_select
);
	wire logic [4:0] st = {low_power_select, path_four_on, path_three_on, path_two_on, path_one_on};
	logic [7:0] oe_cnt;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Counts drive length so a stuck enable is caught
	always @(posedge clk_sys or posedge rst)
		if (rst)
			oe_cnt <= 8'h00;
		else
			oe_cnt <= sdata_oe ? oe_cnt + 8'h01 : 8'h00;
	property p_onehot;
		$onehot0(st[3:0]);
	endproperty
	a_onehot: assert property (p_onehot) else $error("paths not one-hot");
	property p_reset;
		$fell(rst) |-> st == 5'h00 && !sdata_oe;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	property p_read_hold;
		sdata_oe |-> $stable(st);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read changed state");
	property p_oe_min;
		$rose(sdata_oe) |-> sdata_oe [*8];
	endproperty
	a_oe_min: assert property (p_oe_min) else $error("drive too short");
	property p_oe_max;
		oe_cnt < 8'h64;
	endproperty
	a_oe_max: assert property (p_oe_max) else $error("drive too long");
	property p_park;
		$fell(sdata_oe) |-> !$past(sdata_out);
	endproperty
	a_park: assert property (p_park) else $error("no park before release");
	property p_commit;
		$changed(st) |-> !$past(sclk, 2);
	endproperty
	a_commit: assert property (p_commit) else $error("commit off a fall");
	property p_release;
		$fell(sdata_oe) |-> !$past(sclk, 2);
	endproperty
	a_release: assert property (p_release) else $error("release off a fall");
endmodule
bind rffe_switch_control_slave rffe_switch_sva u_sva (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
	.sdata_out(sdata_out), .sdata_oe(sdata_oe), .path_one_on(path_one_on), .path_two_on(path_two_on),
	.path_three_on(path_three_on), .path_four_on(path_four_on), .low_power_select(low_power_select));
`default_nettype wire

/* src/pin_sync.v */
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Pin side and synchronised side
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_sync_out
);

reg [WIDTH-1:0] stage_one;
reg [WIDTH-1:0] stage_two;

// First stage feeds only the second stage
always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		stage_one <= {WIDTH{1'b0}};
		stage_two <= {WIDTH{1'b0}};
	end
	else
	begin
		stage_one <= pin_in;
		stage_two <= stage_one;
	end
end

assign pin_sync_out = stage_two;

endmodule
`default_nettype wire

/* src/rffe_switch_control_slave.v */
// Serial control slave of an RF switch: frame decoder and registers.
// Assumes the link clock is slow against clk_sys (at least 4 cycles a phase).
`timescale 1ns/1ps
`default_nettype none
`include "rffe_switch_regs.vh"

module rffe_switch_control_slave #(
	parameter [3:0] SLAVE_ID = `ID_DEFAULT
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Serial control link
	input wire sclk,
	input wire sdata_in,
	output reg sdata_out,
	output reg sdata_oe,
	// RF switch control
	output wire path_one_on,
	output wire path_two_on,
	output wire path_three_on,
	output wire path_four_on,
	output wire low_power_select
);

// ----------------------------------------------------------------
// Pin synchronisation and edge detection
// ----------------------------------------------------------------
wire [1:0] pins_sync;
reg sclk_prev;
reg sdata_prev;

pin_sync #(
	.WIDTH(2)
) u_pin_sync (
	.clk_sys(clk_sys),
	.rst(rst),
	.pin_in({sclk, sdata_in}),
	.pin_sync_out(pins_sync)
);

wire sclk_s = pins_sync[1];
wire sdata_s = pins_sync[0];
wire sclk_fall = sclk_prev && !sclk_s;
wire sclk_rise = !sclk_prev && sclk_s;
// Data only moves while the clock is high, so a low-to-high-to-low
// pulse on data with the clock low marks a sequence start
wire seq_start = sdata_prev && !sdata_s && !sclk_s;

always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		sclk_prev <= 1'b0;
		sdata_prev <= 1'b0;
	end
	else
	begin
		sclk_prev <= sclk_s;
		sdata_prev <= sdata_s;
	end
end

// ----------------------------------------------------------------
// Frame decoder
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_CMD = 2'b01;
localparam ST_WDATA = 2'b10;
localparam ST_READ = 2'b11;

reg [1:0] state;
reg [4:0] bit_count;
reg [11:0] cmd_shift;
reg [7:0] data_shift;
reg [4:0] frame_addr;
reg frame_allowed;
reg [8:0] read_shift;
reg wr_en;
reg [4:0] wr_addr;
reg [7:0] wr_data;
reg [7:0] read_value;

wire [12:0] cmd_full = {cmd_shift, sdata_s};
wire [3:0] frame_id = cmd_full[12:9];
wire [7:0] frame_cmd = cmd_full[8:1];
wire cmd_parity_ok = ^cmd_full;
wire [8:0] data_full = {data_shift, sdata_s};
wire data_parity_ok = ^data_full;
wire id_own = (frame_id == SLAVE_ID);
wire id_bcast = (frame_id == `ID_BROADCAST);

always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		state <= ST_IDLE;
		bit_count <= 5'h00;
		cmd_shift <= 12'h000;
		data_shift <= 8'h00;
		frame_addr <= 5'h00;
		frame_allowed <= 1'b0;
		read_shift <= 9'h000;
		wr_en <= 1'b0;
		wr_addr <= 5'h00;
		wr_data <= 8'h00;
		sdata_out <= 1'b0;
		sdata_oe <= 1'b0;
	end
	else
	begin
		wr_en <= 1'b0;
		if (seq_start && !sdata_oe)
		begin
			state <= ST_CMD;
			bit_count <= 5'h00;
		end
		else if (sclk_fall && state != ST_IDLE)
		begin
			bit_count <= bit_count + 5'h01;
			case (state)
			ST_CMD:
			begin
				cmd_shift <= cmd_full[11:0];
				if (bit_count == `CNT_CMD_LAST)
				begin
					frame_addr <= frame_cmd[4:0];
					state <= ST_IDLE;
					if (frame_cmd[7])
					begin
						// Short form carries seven data bits for address 0
						wr_en <= cmd_parity_ok && id_own;
						wr_addr <= `ADDR_RF_PATH_SELECT;
						wr_data <= {1'b0, frame_cmd[6:0]};
					end
					else if (frame_cmd[7:5] == `CMD_WRITE)
					begin
						state <= ST_WDATA;
						// Broadcast reaches only the control register
						frame_allowed <= id_own || (id_bcast && frame_cmd[4:0] == `ADDR_POWER_TRIGGER);
					end
					else if (frame_cmd[7:5] == `CMD_READ && cmd_parity_ok && id_own)
					begin
						state <= ST_READ;
						read_shift <= {read_value, ~^read_value};
					end
				end
			end
			ST_WDATA:
			begin
				data_shift <= data_full[7:0];
				if (bit_count == `CNT_DATA_LAST)
				begin
					state <= ST_IDLE;
					// Command parity is held in cmd_good and gates the commit,
					// so a bad parity in either frame drops the write
					wr_en <= frame_allowed && data_parity_ok;
					wr_addr <= frame_addr;
					wr_data <= data_full[8:1];
				end
			end
			ST_READ:
			begin
				if (bit_count + 5'h01 == `CNT_RD_END)
				begin
					sdata_oe <= 1'b0;
					state <= ST_IDLE;
				end
			end
			default:
				state <= ST_IDLE;
			endcase
		end
		else if (sclk_rise && state == ST_READ)
		begin
			if (bit_count >= `CNT_RD_FIRST && bit_count <= `CNT_RD_LAST)
			begin
				sdata_oe <= 1'b1;
				sdata_out <= read_shift[8];
				read_shift <= {read_shift[7:0], 1'b0};
			end
			else if (bit_count == `CNT_RD_PARK)
			begin
				// Drive low for the park cycle, release on the next fall
				sdata_oe <= 1'b1;
				sdata_out <= 1'b0;
			end
		end
	end
end

// The command frame parity has to be held until the data frame ends
reg cmd_good;
always @(posedge clk_sys or posedge rst)
begin
	if (rst)
		cmd_good <= 1'b0;
	else if (sclk_fall && state == ST_CMD && bit_count == `CNT_CMD_LAST)
		cmd_good <= cmd_parity_ok;
end

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg low_power;
reg [2:0] trig_mask;
wire [7:0] rf_path;

// A frame with bad command parity never reaches a register
wire wr_ok = wr_en && cmd_good;
wire wr_rf = wr_ok && (wr_addr == `ADDR_RF_PATH_SELECT);
wire wr_ptc = wr_ok && (wr_addr == `ADDR_POWER_TRIGGER);
wire soft_reset = wr_ptc && wr_data[`BIT_SOFT_RESET];

// ----------------------------------------------------------------
// Trigger strobes
// ----------------------------------------------------------------
// A trigger fires only while its mask bit reads clear; the mask in force
// before this write decides, so unmasking and firing need two writes
// Triggers 1 and 2 own no destination register, so their strobes go unused
localparam TRIG_COUNT = `BIT_TRIG_HI - `BIT_TRIG_LO + 1;
wire trig_write = wr_ptc && !soft_reset;
wire [TRIG_COUNT-1:0] trig_fire;
genvar t;

generate
	for (t = 0; t < TRIG_COUNT; t = t + 1)
	begin : g_trig
		assign trig_fire[t] = trig_write && wr_data[`BIT_TRIG_LO + t] && !trig_mask[t];
	end
endgenerate

always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		low_power <= `LOW_POWER_RESET;
		trig_mask <= `MASK_RESET;
	end
	else if (soft_reset)
	begin
		// Startup state; the soft reset bit itself is never stored
		low_power <= `LOW_POWER_RESET;
		trig_mask <= `MASK_RESET;
	end
	else if (wr_ptc)
	begin
		low_power <= wr_data[`BIT_LOW_POWER];
		trig_mask <= wr_data[`BIT_MASK_HI:`BIT_MASK_LO];
	end
end

trigger_shadow #(
	.WIDTH(8),
	.RESET_VALUE(`RF_PATH_RESET)
) u_rf_path (
	.clk_sys(clk_sys),
	.rst(rst),
	.soft_clear(soft_reset),
	.wr_en(wr_rf),
	.wr_data(wr_data),
	.mask(trig_mask[`TRIG_RF_PATH]),
	.trigger(trig_fire[`TRIG_RF_PATH]),
	.dest(rf_path)
);

// Read data; trigger and soft reset bits read as zero
always @*
begin
	case (frame_cmd[4:0])
	`ADDR_RF_PATH_SELECT:
		read_value = rf_path;
	`ADDR_POWER_TRIGGER:
		read_value = {low_power, 1'b0, trig_mask, 3'h0};
	default:
		read_value = 8'h00;
	endcase
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign path_one_on = rf_path[0];
assign path_two_on = rf_path[1];
assign path_three_on = rf_path[2];
assign path_four_on = rf_path[3];
assign low_power_select = low_power;

endmodule
`default_nettype wire

/* src/rffe_switch_regs.vh */
// Constants for the RF switch serial control slave.
// Assumes inclusion by bare name from the design files under src/.
`ifndef RFFE_SWITCH_REGS_VH
`define RFFE_SWITCH_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_RF_PATH_SELECT 5'h00
`define ADDR_POWER_TRIGGER 5'h1C
`define RF_PATH_RESET 8'h00
`define LOW_POWER_RESET 1'h0
`define MASK_RESET 3'h0

// ----------------------------------------------------------------
// Field positions in power_and_trigger_control
// ----------------------------------------------------------------
`define BIT_LOW_POWER 7
`define BIT_SOFT_RESET 6
`define BIT_MASK_HI 5
`define BIT_MASK_LO 3
`define BIT_TRIG_HI 2
`define BIT_TRIG_LO 0
// Trigger that owns the RF path select shadow
`define TRIG_RF_PATH 0

// ----------------------------------------------------------------
// Frame layout, counted in falling link clock edges after the start
// ----------------------------------------------------------------
`define CNT_CMD_LAST 5'h0C
`define CNT_DATA_LAST 5'h15
`define CNT_RD_FIRST 5'h0E
`define CNT_RD_LAST 5'h16
`define CNT_RD_PARK 5'h17
`define CNT_RD_END 5'h18
`define CMD_WRITE 3'h2
`define CMD_READ 3'h3
`define ID_BROADCAST 4'h0
`define ID_DEFAULT 4'h8

`endif

/* src/trigger_shadow.v */
// Destination register with a shadow copy gated by one trigger.
// Assumes write and trigger strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module trigger_shadow #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	input wire soft_clear,
	// Write and trigger
	input wire wr_en,
	input wire [WIDTH-1:0] wr_data,
	input wire mask,
	input wire trigger,
	// Destination value
	output reg [WIDTH-1:0] dest
);

reg [WIDTH-1:0] shadow;

always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		shadow <= RESET_VALUE;
		dest <= RESET_VALUE;
	end
	else if (soft_clear)
	begin
		shadow <= RESET_VALUE;
		dest <= RESET_VALUE;
	end
	else
	begin
		// Shadow tracks every write so a later trigger never loads stale data
		if (wr_en)
			shadow <= wr_data;
		if (wr_en && mask)
			dest <= wr_data;
		else if (trigger && !mask)
			dest <= shadow;
	end
end

endmodule
`default_nettype wire
